// File: dpram_pkg.sv
/*
 * constants, types and helper functions shared by the dual-port block ram
 * assumes one core clock; port clocks arrive as synchronous level inputs
 */
// Overview of operation
// - each port is 1, 2, 4, 8 or 16 bits wide over 4096 shared cells
// - ports are independent in clock, controls, address, function and width; no arbitration
// - every port input is sampled on that port's own clock edge
// - gated on and store low: addressed cells appear on output after that edge
// - gated on and store high: word written and mirrored on that port's output
// - gate inactive: no write, no output change, read and clear ignored
// - output clear zeroes output latches only; memory and other port untouched
// - output holds until that port's next read or write; glitch free
// - no combinational path from address to output; changes only at clock edge
// - address width is 12 bits at width 1, one fewer per doubling
// - data in and data out are exactly the port width
// - ports read/write, read-only or write-only; single or dual; B not narrower
// - clock, gate, store and clear each have their own polarity inversion
// - port of width W at address A uses bits A*W to (A+1)*W-1
// - read/write collision: write succeeds, writer output correct, reader undefined
package dpram_pkg;

   // ---------------------------------------------------------------
   // array geometry
   // ---------------------------------------------------------------
   localparam int CELL_COUNT = 4096;
   localparam int CELL_BITS  = 12;
   localparam int MAX_WIDTH  = 16;

   // ---------------------------------------------------------------
   // apb register map
   // ---------------------------------------------------------------
   localparam logic [11:0] CTRL_OFFSET   = 12'h000;
   localparam logic [11:0] STATUS_OFFSET = 12'h004;
   localparam int          CTRL_ALLOW_A  = 0;
   localparam int          CTRL_ALLOW_B  = 1;
   localparam logic [1:0]  CTRL_RESET    = 2'h3;
   localparam int          STAT_WROTE_A  = 0;
   localparam int          STAT_WROTE_B  = 1;
   localparam int          STAT_CLEAR_A  = 2;
   localparam int          STAT_CLEAR_B  = 3;

   typedef enum {MODE_RW, MODE_RO, MODE_WO} port_mode_t;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic int width_log2(input int w);
      int r;
      r = 0;
      while ((1 << r) < w) begin
         r = r + 1;
      end
      return r;
   endfunction : width_log2

   function automatic int addr_bits(input int w);
      return CELL_BITS - width_log2(w);
   endfunction : addr_bits

endpackage : dpram_pkg

// File: dual_port_block_ram.sv
/*
 * true dual-port ram of 4096 bit cells with per-port width and an apb control slave
 * assumes all inputs synchronous to core_clk; port clocks are sampled levels
 */
`timescale 1ns/1ps
module dual_port_block_ram
   import dpram_pkg::*;
#(
   parameter int         WIDTH_A   = 1,
   parameter int         WIDTH_B   = 16,
   parameter port_mode_t MODE_A    = MODE_RW,
   parameter port_mode_t MODE_B    = MODE_RW,
   parameter bit         DUAL_PORT = 1'b1,
   parameter logic [3:0] INVERT_A  = 4'h0,
   parameter logic [3:0] INVERT_B  = 4'h0,
   localparam int        AW_A      = addr_bits(WIDTH_A),
   localparam int        AW_B      = addr_bits(WIDTH_B)
) (
   // clock, reset, freeze
   input  wire logic                 core_clk,
   input  wire logic                 rst_n,
   input  wire logic                 ce,
   // port a
   input  wire logic                 port_clk_a,
   input  wire logic                 gate_a,
   input  wire logic                 store_a,
   input  wire logic                 out_clear_a,
   input  wire logic [AW_A-1:0]      addr_a,
   input  wire logic [WIDTH_A-1:0]   write_word_in_a,
   output logic      [WIDTH_A-1:0]   read_word_out_a,
   // port b
   input  wire logic                 port_clk_b,
   input  wire logic                 gate_b,
   input  wire logic                 store_b,
   input  wire logic                 out_clear_b,
   input  wire logic [AW_B-1:0]      addr_b,
   input  wire logic [WIDTH_B-1:0]   write_word_in_b,
   output logic      [WIDTH_B-1:0]   read_word_out_b,
   // apb slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr
);

   // ---------------------------------------------------------------
   // per-port view, index 0 = a, 1 = b
   // ---------------------------------------------------------------
   localparam int         WID[2]  = '{WIDTH_A, WIDTH_B};
   localparam port_mode_t MODE[2] = '{MODE_A, MODE_B};
   localparam logic [3:0] INV[2]  = '{INVERT_A, INVERT_B};
   localparam int         INV_CLK = 0;
   localparam int         INV_EN  = 1;
   localparam int         INV_WE  = 2;
   localparam int         INV_RST = 3;

   logic                 mem [CELL_COUNT];
   logic                 pin_clk [2];
   logic                 pin_gate [2];
   logic                 pin_store [2];
   logic                 pin_clear [2];
   logic [CELL_BITS-1:0] pin_addr [2];
   logic [MAX_WIDTH-1:0] pin_din [2];
   logic [MAX_WIDTH-1:0] dout [2];
   logic [MAX_WIDTH-1:0] cells [2];
   logic [CELL_BITS-1:0] base [2];
   logic                 clk_prev [2];
   logic                 active [2];
   logic                 do_write [2];
   logic                 do_read [2];
   logic                 do_clear [2];
   logic                 wrote [2];
   logic                 cleared [2];
   logic [1:0]           ctrl;

   // address is widened to 12 bits before scaling by the width
   assign pin_clk[0]   = port_clk_a;
   assign pin_clk[1]   = port_clk_b;
   assign pin_gate[0]  = gate_a;
   assign pin_gate[1]  = gate_b & DUAL_PORT;
   assign pin_store[0] = store_a;
   assign pin_store[1] = store_b;
   assign pin_clear[0] = out_clear_a;
   assign pin_clear[1] = out_clear_b;
   assign pin_addr[0]  = CELL_BITS'(addr_a);
   assign pin_addr[1]  = CELL_BITS'(addr_b);
   assign pin_din[0]   = MAX_WIDTH'(write_word_in_a);
   assign pin_din[1]   = MAX_WIDTH'(write_word_in_b);

   assign read_word_out_a = dout[0][WIDTH_A-1:0];
   assign read_word_out_b = dout[1][WIDTH_B-1:0];

   // ---------------------------------------------------------------
   // port decode: edge, gate, function
   // ---------------------------------------------------------------
   for (genvar p = 0; p < 2; p++) begin : g_port
      logic clk_lvl;
      logic gate_on;
      logic store_on;

      // each control pin (clock, gate, store, clear) is xored with its own inversion bit
      assign clk_lvl     = pin_clk[p] ^ INV[p][INV_CLK];
      assign gate_on     = (pin_gate[p] ^ INV[p][INV_EN]) & ctrl[p];
      assign store_on    = pin_store[p] ^ INV[p][INV_WE];
      assign active[p]   = clk_lvl & ~clk_prev[p] & gate_on & ce;
      assign do_write[p] = active[p] & store_on & (MODE[p] != MODE_RO);
      assign do_read[p]  = active[p] & ~store_on & (MODE[p] != MODE_WO);
      assign do_clear[p] = active[p] & (pin_clear[p] ^ INV[p][INV_RST]);
      assign base[p]     = CELL_BITS'(pin_addr[p] << width_log2(WID[p]));

      // slice of the shared array; only sampled at an active edge
      always_comb begin
         cells[p] = '0;
         for (int i = 0; i < WID[p]; i++) begin
            cells[p][i] = mem[int'(base[p]) + i];
         end
      end

      // ---------------------------------------------------------------
      // output latch: only moves on an active edge, so it never glitches
      // ---------------------------------------------------------------
      always_ff @(posedge core_clk) begin
         if (!rst_n) begin
            clk_prev[p] <= 1'b0;
            dout[p]     <= '0;
            wrote[p]    <= 1'b0;
            cleared[p]  <= 1'b0;
         end else if (ce) begin
            clk_prev[p] <= clk_lvl;
            if (do_clear[p]) begin
               dout[p]    <= '0;
               cleared[p] <= 1'b1;
               wrote[p]   <= do_write[p];
            end else if (do_write[p]) begin
               dout[p]    <= pin_din[p];
               cleared[p] <= 1'b0;
               wrote[p]   <= 1'b1;
            end else if (do_read[p]) begin
               dout[p]    <= cells[p];
               cleared[p] <= 1'b0;
               wrote[p]   <= 1'b0;
            end
            // otherwise the latch holds its value
         end
      end
   end

   // ---------------------------------------------------------------
   // shared array, no arbitration; overlapping writes land b last
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      for (int p = 0; p < 2; p++) begin
         if (do_write[p]) begin
            for (int i = 0; i < WID[p]; i++) begin
               mem[int'(base[p]) + i] <= pin_din[p][i];
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // apb slave: zero wait states unless frozen
   // ---------------------------------------------------------------
   logic        hit_ctrl;
   logic        hit_status;
   logic        apb_access;
   logic [31:0] next_prdata;

   assign hit_ctrl    = (paddr == CTRL_OFFSET);
   assign hit_status  = (paddr == STATUS_OFFSET);
   assign apb_access  = psel & penable & ce;
   assign pready      = ce;
   assign pslverr     = psel & penable & ~(hit_ctrl | hit_status);
   assign next_prdata = hit_ctrl   ? {30'h0, ctrl} :
                        hit_status ? {28'h0, cleared[1], cleared[0], wrote[1], wrote[0]} :
                        32'h0000_0000;

   // read data is captured in the setup cycle so it comes from a flop
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ctrl   <= CTRL_RESET;
         prdata <= 32'h0000_0000;
      end else if (ce) begin
         if (psel & ~penable & ~pwrite) begin
            prdata <= next_prdata;
         end
         if (apb_access & pwrite & hit_ctrl) begin
            ctrl <= pwdata[1:0];
         end
      end
   end

endmodule : dual_port_block_ram

// File: dpram_user.sv
/* user logic driving one ram port, one operation at a time
   assumes the bench clock; port clock idles low between operations */
`timescale 1ns/1ps
module dpram_user #(
   parameter int W  = 4,
   parameter int AW = 10
) (
   // clock
   input  wire logic          core_clk,
   // ram port
   output logic              pclk, gate, store, clr,
   output logic [AW-1:0]     addr,
   output logic [W-1:0]      data
);
   initial {pclk, gate, store, clr, addr, data} = '0;
   task op(input logic g, s, c, input logic [AW-1:0] a, input logic [W-1:0] d);
      @(posedge core_clk);
      {pclk, gate, store, clr, addr, data} <= {1'b0, g, s, c, a, d};
      @(posedge core_clk);
      pclk <= 1'b1;
      @(posedge core_clk);
      // released address and data lines show the inverse, never a stale copy; pclk and gate drop low
      {pclk, gate, addr, data} <= {1'b0, 1'b0, ~a, ~d};
      #1;
   endtask : op
endmodule : dpram_user

// File: dpram_chk_sva.sv
/* assertions on the ram ports and the apb slave
   bound to the ram top; port a allow bit assumed kept set */
`timescale 1ns/1ps
module dpram_chk #(
   parameter int WIDTH_A = 1,
   parameter int WIDTH_B = 16
) (
   input wire logic core_clk, rst_n, ce, port_clk_a, gate_a, store_a, out_clear_a,
   input wire logic [WIDTH_A-1:0] write_word_in_a, read_word_out_a,
   input wire logic port_clk_b, gate_b,
   input wire logic [WIDTH_B-1:0] read_word_out_b,
   input wire logic psel, penable, pready, pslverr,
   input wire logic [11:0] paddr
);
   logic last_a, last_b;
   wire  edge_a = ce & port_clk_a & ~last_a & gate_a;
   wire  edge_b = ce & port_clk_b & ~last_b & gate_b;
   wire  mapped = (paddr == 12'h000) || (paddr == 12'h004);
   // history frozen with ce, as the port sampler is
   always_ff @(posedge core_clk) begin
      last_a <= rst_n & (ce ? port_clk_a : last_a);
      last_b <= rst_n & (ce ? port_clk_b : last_b);
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence wr_a; edge_a && store_a && !out_clear_a; endsequence
   sequence clr_a; edge_a && out_clear_a; endsequence
   a_mirror_a: assert property (wr_a |=> read_word_out_a == $past(write_word_in_a))
      else $error("port a write not mirrored");
   a_clear_read: assert property (clr_a ##0 !store_a |=> read_word_out_a == '0)
      else $error("port a clear missed");
   a_clear_write: assert property (clr_a ##0 store_a |=> read_word_out_a == '0)
      else $error("port a clear lost to write");
   a_clear_holds: assert property (clr_a ##1 !edge_a [*2] |=> read_word_out_a == '0)
      else $error("port a cleared output moved");
   a_hold_a: assert property (!edge_a |=> $stable(read_word_out_a))
      else $error("port a output moved without edge");
   a_hold_b: assert property (!edge_b |=> $stable(read_word_out_b))
      else $error("port b output moved without edge");
   a_ready_ce: assert property (pready == ce)
      else $error("pready differs from ce");
   a_bad_addr: assert property (psel && penable && !mapped |-> pslverr)
      else $error("unmapped access without error");
   a_err_access: assert property (!(psel && penable) || mapped |-> !pslverr)
      else $error("error outside unmapped access");
endmodule : dpram_chk
bind dual_port_block_ram dpram_chk #(.WIDTH_A(WIDTH_A), .WIDTH_B(WIDTH_B)) u_dpram_chk (
   .core_clk, .rst_n, .ce, .port_clk_a, .gate_a, .store_a, .out_clear_a, .write_word_in_a,
   .read_word_out_a, .port_clk_b, .gate_b, .read_word_out_b, .psel, .penable, .pready,
   .pslverr, .paddr);

// File: tb_dual_port_block_ram.sv
/* self-checking bench for the dual-port ram against a bit-level model
   assumes two user-side drivers and the bound checker */
`timescale 1ns/1ps
module tb_dual_port_block_ram;
   localparam int WA = 4, WB = 16, AWA = 10, AWB = 8;
   logic        core_clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, r;
   logic [1:0]  allow = 2'h3;
   wire         port_clk_a, gate_a, store_a, out_clear_a;
   wire         port_clk_b, gate_b, store_b, out_clear_b;
   wire [AWA-1:0] addr_a;
   wire [AWB-1:0] addr_b;
   wire [WA-1:0]  write_word_in_a, read_word_out_a;
   wire [WB-1:0]  write_word_in_b, read_word_out_b;
   int num_errors = 0, checks = 0, seed = 32'ha56f, cyc = 0;
   int mem_m [4096];
   dual_port_block_ram #(.WIDTH_A(WA), .WIDTH_B(WB)) u_dual_port_block_ram (
      .core_clk, .rst_n, .ce, .port_clk_a, .gate_a, .store_a, .out_clear_a, .addr_a,
      .write_word_in_a, .read_word_out_a, .port_clk_b, .gate_b, .store_b, .out_clear_b,
      .addr_b, .write_word_in_b, .read_word_out_b, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr);
   dpram_user #(.W(WA), .AW(AWA)) u_pa (.core_clk, .pclk(port_clk_a), .gate(gate_a),
      .store(store_a), .clr(out_clear_a), .addr(addr_a), .data(write_word_in_a));
   dpram_user #(.W(WB), .AW(AWB)) u_pb (.core_clk, .pclk(port_clk_b), .gate(gate_b),
      .store(store_b), .clr(out_clear_b), .addr(addr_b), .data(write_word_in_b));
   initial forever #20 core_clk = ~core_clk;
   // ---
   // shared tasks
   // ---
   task conclude;
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude
   task check(input string what, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   function automatic int mget(int a, w);
      int v = 0;
      for (int i = 0; i < w; i++) v |= mem_m[a * w + i] << i;
      return v;
   endfunction : mget
   task apb(input bit w, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
      if (w && a == 12'h000) allow = d[1:0];
   endtask : apb
   task automatic do_op(input bit pb, g, s, c, input int a, d);
      int w;
      bit tk;
      logic [31:0] prev;
      logic [31:0] seen;
      logic [31:0] exp;
      w = pb ? WB : WA;
      tk = g && ce && allow[pb];
      prev = pb ? 32'(read_word_out_b) : 32'(read_word_out_a);
      if (pb) u_pb.op(g, s, c, a[AWB-1:0], d[WB-1:0]);
      else u_pa.op(g, s, c, a[AWA-1:0], d[WA-1:0]);
      if (tk && s) for (int i = 0; i < w; i++) mem_m[a * w + i] = (d >> i) & 1;
      seen = pb ? 32'(read_word_out_b) : 32'(read_word_out_a);
      exp = !tk ? prev : c ? 0 : mget(a, w);
      check(pb ? "b out" : "a out", seen, exp);
   endtask : do_op
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 10000) begin
         num_errors++;
         conclude();
      end
   end
   // ---
   // main sequence
   // ---
   initial begin
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      apb(0, 12'h000, 0); check("ctrl", rd, 32'h3);
      apb(0, 12'h004, 0); check("status", rd, 32'h0);
      apb(0, 12'h008, 0); check("bad err", 32'(er), 1); check("bad data", rd, 0);
      apb(1, 12'h004, 32'hf); check("ro err", 32'(er), 0);
      apb(0, 12'h004, 0); check("status ro", rd, 32'h0);
      for (int i = 0; i < 256; i++) do_op(1, 1, 1, 0, i, $random(seed));
      for (int i = 0; i < 300; i++) begin
         r = $random(seed);
         if (r[0]) do_op(0, r[5] | r[1], r[1], r[2] & r[3] & r[4], r[15:6], r[31:16]);
         else do_op(1, r[5] | r[1], r[1], r[2] & r[3] & r[4], r[13:6], r[31:16]);
      end
      do_op(0, 1, 1, 1, 5, 9);
      apb(0, 12'h004, 0); check("status a", rd & 32'h5, 32'h5);
      do_op(0, 0, 1, 0, 5, 3);
      do_op(0, 1, 0, 0, 5, 0);
      @(posedge core_clk) ce <= 1'b0;
      @(posedge core_clk);
      do_op(1, 1, 1, 0, 7, 16'h1234); check("frozen ready", 32'(pready), 0);
      @(posedge core_clk) ce <= 1'b1;
      apb(1, 12'h000, 1);
      do_op(1, 1, 1, 0, 9, 16'h0f0f);
      apb(1, 12'h000, 3);
      do_op(1, 1, 0, 0, 9, 0);
      fork // distinct cells only, each port expects its own written word mirrored
         do_op(0, 1, 1, 0, 0, 10);
         do_op(1, 1, 1, 0, 200, 16'h5aa5);
      join
      do_op(1, 1, 0, 0, 0, 0);
      conclude();
   end
endmodule : tb_dual_port_block_ram
